// file: shared/trc_pkg.sv
`default_nettype none
package trc_pkg;
// Overview of operation
// - At power-up show identity and firmware version, then measure and display.
// - Outside permissible range show high or low range warning instead of value.
// - In range but display beyond -999..9999 shows the overflow warning.
// - Up/down key shows threshold name and value; in two-threshold modes a repress within 5 s advances.
// - Register writes never stop measuring or output control.
// - A peak counts only after a rise then a fall of at least crest_min_swing.
// - Peak shown for crest_show_duration; a new peak replaces it and restarts timing.
// - With no new peak before expiry, display returns to the current value.
// - Relay and LED follow current or held peak value, per configuration.
// - Polarity setting makes the relay unused, one-threshold or two-threshold.
// - Border values are threshold plus and minus dead_band_width.
// - One threshold: polarity on energises in zone A, off de-energises there.
// - With both delays zero the relay switches at once on crossing a border.
// - Positive on_delay: switch on only after staying beyond border that long.
// - Positive off_delay: switch off only once off_delay elapsed since crossing.
// - A zone stay shorter than the applicable delay leaves the relay unchanged.
// - Delay counts are scaled by a selectable time base.
// - On fault the relay is forced on, forced off or held per fault_output_choice.
// - Two-threshold mode shares band, polarity, delays, time base and fault action.
// - Two thresholds: in energises between thresholds, out energises outside.
// - Thresholds may be in either order; span between them is zone A.
// - LED mirrors relay; with no relay fitted the LED alone shows the decision.

localparam int unsigned CLK_MHZ = 50;
localparam int unsigned DW      = 16;
localparam int unsigned AW      = 4;

localparam logic [3:0] REG_CTRL  = 4'h0;
localparam logic [3:0] REG_THR1  = 4'h1;
localparam logic [3:0] REG_THR2  = 4'h2;
localparam logic [3:0] REG_BAND  = 4'h3;
localparam logic [3:0] REG_TON   = 4'h4;
localparam logic [3:0] REG_OFF_DELAY  = 4'h5;
localparam logic [3:0] REG_SWING = 4'h6;
localparam logic [3:0] REG_SHOW  = 4'h7;
localparam logic [3:0] REG_STAT  = 4'h8;
localparam logic [3:0] REG_PEAK  = 4'h9;

localparam logic [15:0] CTRL_RST  = 16'h0000;
localparam logic [15:0] THR1_RST  = 16'h0000;
localparam logic [15:0] THR2_RST  = 16'h0000;
localparam logic [15:0] BAND_RST  = 16'h0000;
localparam logic [15:0] TON_RST   = 16'h0000;
localparam logic [15:0] OFF_DELAY_RST  = 16'h0000;
localparam logic [15:0] SWING_RST = 16'h0001;
localparam logic [15:0] SHOW_RST  = 16'h000a;

localparam logic [2:0] MODE_UNUSED = 3'h0;
localparam logic [2:0] MODE_ON     = 3'h1;
localparam logic [2:0] MODE_OFF    = 3'h2;
localparam logic [2:0] MODE_IN     = 3'h3;
localparam logic [2:0] MODE_OUT    = 3'h4;
localparam logic [1:0] FLT_HOLD    = 2'h0;
localparam logic [1:0] FLT_ON      = 2'h1;
localparam logic [1:0] FLT_OFF     = 2'h2;

localparam logic signed [16:0] DISP_MAX = 17'sh0270f;
localparam logic signed [16:0] DISP_MIN = -17'sh003e7;

localparam int unsigned BOOT_MS    = 1000;
localparam int unsigned VIEW_MS    = 5000;
localparam int unsigned ALT_MS     = 500;
localparam int unsigned TB_FAST_MS = 100;
localparam int unsigned TB_SLOW_MS = 1000;
localparam int unsigned BOOT_CYC    = BOOT_MS * 1000 * CLK_MHZ;
localparam int unsigned VIEW_CYC    = VIEW_MS * 1000 * CLK_MHZ;
localparam int unsigned ALT_CYC     = ALT_MS * 1000 * CLK_MHZ;
localparam int unsigned TB_FAST_CYC = TB_FAST_MS * 1000 * CLK_MHZ;
localparam int unsigned TB_SLOW_CYC = TB_SLOW_MS * 1000 * CLK_MHZ;

typedef enum logic [2:0] {
    ST_BOOT = 3'b001,
    ST_MEAS = 3'b010,
    ST_VIEW = 3'b100
} trc_state_t;

typedef enum logic [2:0] {
    DK_IDENT = 3'h0,
    DK_VALUE = 3'h1,
    DK_HIGH  = 3'h2,
    DK_LOW   = 3'h3,
    DK_OVER  = 3'h4,
    DK_NAME  = 3'h5,
    DK_THR   = 3'h6
} trc_disp_t;

typedef struct packed {
    logic       unit;
    logic [1:0] fault;
    logic       src_peak;
    logic [2:0] mode;
} trc_ctrl_t;

typedef struct packed {
    logic               valid;
    logic               over;
    logic               under;
    logic signed [15:0] value;
} trc_meas_t;

endpackage
`default_nettype wire

// file: src/trc_relay_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module trc_relay_ctrl #(
    parameter int unsigned BOOT_LEN = trc_pkg::BOOT_CYC,
    parameter int unsigned VIEW_LEN = trc_pkg::VIEW_CYC,
    parameter int unsigned ALT_LEN  = trc_pkg::ALT_CYC,
    parameter int unsigned TB_FAST  = trc_pkg::TB_FAST_CYC,
    parameter int unsigned TB_SLOW  = trc_pkg::TB_SLOW_CYC,
    parameter bit          RELAY_FITTED = 1'b1,
    parameter logic [15:0] ID_CODE  = 16'h0a51,
    parameter logic [15:0] FW_VER   = 16'h0001
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [15:0]            reg_rdata,
    input  wire trc_pkg::trc_meas_t meas,
    input  wire logic              key_up,
    input  wire logic              key_down,
    output logic                   relay_out,
    output logic                   led_out,
    output trc_pkg::trc_disp_t     disp_kind,
    output logic [15:0]            disp_value
);
    // Configuration registers; writes never touch the measuring path
    trc_pkg::trc_ctrl_t ctrl, next_ctrl;
    logic [15:0] thr1, thr2, band, ton, off_delay, swing, show;
    logic [15:0] next_thr1, next_thr2, next_band, next_ton, next_off_delay;
    logic [15:0] next_swing, next_show, next_rdata;
    logic        rel_state, in_a, in_b, fault, peak_act;
    logic signed [15:0] peak_val, cur_val;
    trc_pkg::trc_state_t st;

    always_comb begin
        next_ctrl  = ctrl;
        next_thr1  = thr1;
        next_thr2  = thr2;
        next_band  = band;
        next_ton   = ton;
        next_off_delay  = off_delay;
        next_swing = swing;
        next_show  = show;
        if (reg_wr) begin
            case (reg_addr)
                trc_pkg::REG_CTRL:  next_ctrl  = trc_pkg::trc_ctrl_t'(reg_wdata[6:0]);
                trc_pkg::REG_THR1:  next_thr1  = reg_wdata;
                trc_pkg::REG_THR2:  next_thr2  = reg_wdata;
                trc_pkg::REG_BAND:  next_band  = reg_wdata;
                trc_pkg::REG_TON:   next_ton   = reg_wdata;
                trc_pkg::REG_OFF_DELAY:  next_off_delay  = reg_wdata;
                trc_pkg::REG_SWING: next_swing = reg_wdata;
                trc_pkg::REG_SHOW:  next_show  = reg_wdata;
                default: ;
            endcase
        end
        next_rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                trc_pkg::REG_CTRL:  next_rdata = {9'h000, ctrl};
                trc_pkg::REG_THR1:  next_rdata = thr1;
                trc_pkg::REG_THR2:  next_rdata = thr2;
                trc_pkg::REG_BAND:  next_rdata = band;
                trc_pkg::REG_TON:   next_rdata = ton;
                trc_pkg::REG_OFF_DELAY:  next_rdata = off_delay;
                trc_pkg::REG_SWING: next_rdata = swing;
                trc_pkg::REG_SHOW:  next_rdata = show;
                trc_pkg::REG_STAT:  next_rdata = {8'h00, st, in_b, in_a, fault, peak_act, rel_state};
                trc_pkg::REG_PEAK:  next_rdata = peak_val;
                default:            next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl      <= trc_pkg::trc_ctrl_t'(trc_pkg::CTRL_RST[6:0]);
            thr1      <= trc_pkg::THR1_RST;
            thr2      <= trc_pkg::THR2_RST;
            band      <= trc_pkg::BAND_RST;
            ton       <= trc_pkg::TON_RST;
            off_delay      <= trc_pkg::OFF_DELAY_RST;
            swing     <= trc_pkg::SWING_RST;
            show      <= trc_pkg::SHOW_RST;
            reg_rdata <= 16'h0000;
        end else begin
            ctrl      <= next_ctrl;
            thr1      <= next_thr1;
            thr2      <= next_thr2;
            band      <= next_band;
            ton       <= next_ton;
            off_delay      <= next_off_delay;
            swing     <= next_swing;
            show      <= next_show;
            reg_rdata <= next_rdata;
        end
    end

    // Latest sample and peak detector
    logic               over_q, under_q, armed, peak_hit, ptick;
    logic signed [15:0] trough, crest;
    logic signed [15:0] next_cur, next_trough, next_crest, next_peak;
    logic               next_over, next_under, next_armed, next_pact;
    logic [31:0]        pscale, next_pscale;
    logic [15:0]        show_cnt, next_show_cnt;
    logic signed [16:0] rise, fall;

    assign fault = over_q | under_q;
    assign ptick = (pscale == 32'(TB_FAST - 1));

    always_comb begin
        next_cur    = cur_val;
        next_over   = over_q;
        next_under  = under_q;
        next_trough = trough;
        next_crest  = crest;
        next_armed  = armed;
        next_peak   = peak_val;
        next_pact   = peak_act;
        peak_hit    = 1'b0;
        rise = {meas.value[15], meas.value} - {trough[15], trough};
        fall = {crest[15], crest} - {meas.value[15], meas.value};
        next_pscale   = ptick ? 32'h0000_0000 : pscale + 32'h0000_0001;
        next_show_cnt = show_cnt;
        if (peak_act && ptick) begin
            next_show_cnt = show_cnt + 16'h0001;
        end
        if (peak_act && show_cnt >= show) begin
            next_pact = 1'b0;
        end
        if (meas.valid) begin
            next_cur   = meas.value;
            next_over  = meas.over;
            next_under = meas.under;
            if (!meas.over && !meas.under) begin
                if (meas.value < trough && !armed) begin
                    next_trough = meas.value;
                end
                if (!armed || meas.value > crest) begin
                    next_crest = meas.value;
                end
                if (rise >= $signed({1'b0, swing})) begin
                    next_armed = 1'b1;
                end
                if (armed && fall >= $signed({1'b0, swing})) begin
                    peak_hit      = 1'b1;
                    next_peak     = crest;
                    next_pact     = 1'b1;
                    next_show_cnt = 16'h0000;
                    next_armed    = 1'b0;
                    next_trough   = meas.value;
                    next_crest    = meas.value;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_val  <= 16'sh0000;
            over_q   <= 1'b0;
            under_q  <= 1'b0;
            trough   <= 16'sh7fff;
            crest    <= 16'sh8000;
            armed    <= 1'b0;
            peak_val <= 16'sh0000;
            peak_act <= 1'b0;
            pscale   <= 32'h0000_0000;
            show_cnt <= 16'h0000;
        end else begin
            cur_val  <= next_cur;
            over_q   <= next_over;
            under_q  <= next_under;
            trough   <= next_trough;
            crest    <= next_crest;
            armed    <= next_armed;
            peak_val <= next_peak;
            peak_act <= next_pact;
            pscale   <= next_pscale;
            show_cnt <= next_show_cnt;
        end
    end

    peak_restart_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        peak_hit |=> (peak_act && show_cnt == 16'h0000 && peak_val == $past(crest)))
        else $error("peak not latched with cleared timer");
    peak_expire_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (peak_act && show_cnt >= show && !peak_hit) |=> !peak_act)
        else $error("peak display did not expire");

    // Relay zone decision and delay timing
    logic signed [15:0] src, lo, hi;
    logic signed [16:0] lo_up, lo_dn, hi_up, hi_dn, sx;
    logic        two, en_a, target, pending, tbtick, next_rel;
    logic [15:0] dly_cnt, next_dly, dly_need;
    logic [31:0] tb_cnt, next_tb, tb_len;

    always_comb begin
        src  = (ctrl.src_peak && peak_act) ? peak_val : cur_val;
        two  = (ctrl.mode == trc_pkg::MODE_IN) || (ctrl.mode == trc_pkg::MODE_OUT);
        lo   = ($signed(thr1) < $signed(thr2) || !two) ? $signed(thr1) : $signed(thr2);
        hi   = ($signed(thr1) < $signed(thr2)) ? $signed(thr2) : $signed(thr1);
        sx   = {src[15], src};
        lo_up = {lo[15], lo} + $signed({1'b0, band});
        lo_dn = {lo[15], lo} - $signed({1'b0, band});
        hi_up = {hi[15], hi} + $signed({1'b0, band});
        hi_dn = {hi[15], hi} - $signed({1'b0, band});
        if (two) begin
            in_a = (sx > lo_up) && (sx < hi_dn);
            in_b = (sx < lo_dn) || (sx > hi_up);
        end else begin
            in_a = sx > lo_up;
            in_b = sx < lo_dn;
        end
        en_a = (ctrl.mode == trc_pkg::MODE_ON) || (ctrl.mode == trc_pkg::MODE_IN);
        target = rel_state;
        if (in_a) begin
            target = en_a;
        end else if (in_b) begin
            target = !en_a;
        end
        pending  = target != rel_state;
        dly_need = target ? ton : off_delay;
        tb_len   = ctrl.unit ? 32'(TB_SLOW) : 32'(TB_FAST);
        tbtick   = tb_cnt == tb_len - 32'h0000_0001;
        next_rel = rel_state;
        next_dly = 16'h0000;
        next_tb  = 32'h0000_0000;
        if (ctrl.mode == trc_pkg::MODE_UNUSED) begin
            next_rel = 1'b0;
        end else if (fault) begin
            case (ctrl.fault)
                trc_pkg::FLT_ON:  next_rel = 1'b1;
                trc_pkg::FLT_OFF: next_rel = 1'b0;
                default:          next_rel = rel_state;
            endcase
        end else if (pending) begin
            if (dly_cnt >= dly_need) begin
                next_rel = target;
            end else begin
                next_tb  = tbtick ? 32'h0000_0000 : tb_cnt + 32'h0000_0001;
                next_dly = tbtick ? dly_cnt + 16'h0001 : dly_cnt;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rel_state <= 1'b0;
            dly_cnt   <= 16'h0000;
            tb_cnt    <= 32'h0000_0000;
            relay_out <= 1'b0;
            led_out   <= 1'b0;
        end else begin
            rel_state <= next_rel;
            dly_cnt   <= next_dly;
            tb_cnt    <= next_tb;
            relay_out <= next_rel & RELAY_FITTED;
            led_out   <= next_rel;
        end
    end

    zero_delay_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ton == 16'h0000 && off_delay == 16'h0000 && pending && !fault
         && ctrl.mode != trc_pkg::MODE_UNUSED) |=> rel_state == $past(target))
        else $error("zero delay relay did not switch at once");
    delay_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pending && !fault && dly_cnt < dly_need
         && ctrl.mode != trc_pkg::MODE_UNUSED) |=> $stable(rel_state))
        else $error("relay switched before its delay");
    band_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!in_a && !in_b && !fault && ctrl.mode != trc_pkg::MODE_UNUSED)
        |=> rel_state == $past(rel_state))
        else $error("relay moved inside dead band");
    fault_force_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (fault && ctrl.mode != trc_pkg::MODE_UNUSED && ctrl.fault != trc_pkg::FLT_HOLD)
        |=> rel_state == ($past(ctrl.fault) == trc_pkg::FLT_ON))
        else $error("fault action not applied");
    led_mirror_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 (led_out == rel_state) && (relay_out == (rel_state & RELAY_FITTED)))
        else $error("led or relay out of step with decision");

    // Display sequencing and quick threshold view
    trc_pkg::trc_state_t next_st;
    trc_pkg::trc_disp_t  next_kind;
    logic [31:0]        cnt, next_cnt, alt_cnt, next_alt;
    logic               alt_ph, next_alt_ph, vidx, next_vidx, key;
    logic [15:0]        next_dval;
    logic signed [15:0] shown;

    assign key = key_up | key_down;

    always_comb begin
        next_st     = st;
        next_cnt    = cnt + 32'h0000_0001;
        next_vidx   = vidx;
        next_alt    = (alt_cnt == 32'(ALT_LEN - 1)) ? 32'h0000_0000 : alt_cnt + 32'h0000_0001;
        next_alt_ph = (alt_cnt == 32'(ALT_LEN - 1)) ? !alt_ph : alt_ph;
        case (st)
            trc_pkg::ST_BOOT: begin
                if (cnt == 32'(BOOT_LEN - 1)) begin
                    next_st  = trc_pkg::ST_MEAS;
                    next_cnt = 32'h0000_0000;
                end
            end
            trc_pkg::ST_MEAS: begin
                next_cnt = 32'h0000_0000;
                if (key) begin
                    next_st     = trc_pkg::ST_VIEW;
                    next_vidx   = 1'b0;
                    next_alt    = 32'h0000_0000;
                    next_alt_ph = 1'b0;
                end
            end
            trc_pkg::ST_VIEW: begin
                if (key) begin
                    next_cnt  = 32'h0000_0000;
                    next_vidx = two ? !vidx : 1'b0;
                end else if (cnt == 32'(VIEW_LEN - 1)) begin
                    next_st  = trc_pkg::ST_MEAS;
                    next_cnt = 32'h0000_0000;
                end
            end
            default: begin
                next_st  = trc_pkg::ST_MEAS;
                next_cnt = 32'h0000_0000;
            end
        endcase
        shown     = peak_act ? peak_val : cur_val;
        next_kind = trc_pkg::DK_VALUE;
        next_dval = shown;
        case (st)
            trc_pkg::ST_BOOT: begin
                next_kind = trc_pkg::DK_IDENT;
                next_dval = (cnt < 32'(BOOT_LEN / 2)) ? ID_CODE : FW_VER;
            end
            trc_pkg::ST_VIEW: begin
                next_kind = alt_ph ? trc_pkg::DK_THR : trc_pkg::DK_NAME;
                next_dval = alt_ph ? (vidx ? thr2 : thr1) : {15'h0000, vidx};
            end
            default: begin
                if (over_q) begin
                    next_kind = trc_pkg::DK_HIGH;
                end else if (under_q) begin
                    next_kind = trc_pkg::DK_LOW;
                end else if ($signed({shown[15], shown}) > trc_pkg::DISP_MAX
                             || $signed({shown[15], shown}) < trc_pkg::DISP_MIN) begin
                    next_kind = trc_pkg::DK_OVER;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st         <= trc_pkg::ST_BOOT;
            cnt        <= 32'h0000_0000;
            alt_cnt    <= 32'h0000_0000;
            alt_ph     <= 1'b0;
            vidx       <= 1'b0;
            disp_kind  <= trc_pkg::DK_IDENT;
            disp_value <= 16'h0000;
        end else begin
            st         <= next_st;
            cnt        <= next_cnt;
            alt_cnt    <= next_alt;
            alt_ph     <= next_alt_ph;
            vidx       <= next_vidx;
            disp_kind  <= next_kind;
            disp_value <= next_dval;
        end
    end

    boot_ident_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st == trc_pkg::ST_BOOT && cnt == 32'(BOOT_LEN - 1))
        |=> st == trc_pkg::ST_MEAS ##1 disp_kind != trc_pkg::DK_IDENT)
        else $error("boot did not hand over to measuring");
    range_warn_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st == trc_pkg::ST_MEAS && over_q) |=> disp_kind == trc_pkg::DK_HIGH)
        else $error("high range warning missing");
    disp_overflow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st == trc_pkg::ST_MEAS && !fault && !peak_act && $signed(cur_val) > 16'sh270f)
        |=> disp_kind == trc_pkg::DK_OVER)
        else $error("display overflow warning missing");
    view_timeout_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st == trc_pkg::ST_VIEW && !key && cnt == 32'(VIEW_LEN - 1))
        |=> st == trc_pkg::ST_MEAS)
        else $error("quick view did not time out");
endmodule
`default_nettype wire

// file: tb/trc_conv_model.sv
`timescale 1ns/1ns
`default_nettype none
module trc_conv_model (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic               send,
    input  wire logic signed [15:0] value,
    input  wire logic               over,
    input  wire logic               under,
    output var trc_pkg::trc_meas_t  meas
);
    // Result stands only beside the valid pulse; between pulses the value toggles
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meas <= '0;
        end else if (send) begin
            meas <= {1'b1, over, under, value};
        end else begin
            meas <= {3'b000, ~meas.value};
        end
    end
endmodule
`default_nettype wire

// file: tb/test_trc_relay_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module test_trc_relay_ctrl;
    typedef struct packed {logic [2:0] mode; logic [15:0] v; logic exp;} trc_row_t;
    logic ref_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, send = 1'b0;
    logic ov = 1'b0, un = 1'b0, k_up = 1'b0, k_dn = 1'b0, relay, led;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, val = 16'h0000, dval;
    trc_pkg::trc_meas_t meas;
    trc_pkg::trc_disp_t dk;
    int n_fail = 0, cmp_count = 0;
    trc_row_t rows [12] = '{
        '{3'h1, 16'h0190, 1'b1}, '{3'h1, 16'h0131, 1'b1}, '{3'h1, 16'h00c8, 1'b0},
        '{3'h1, 16'h0127, 1'b0}, '{3'h2, 16'h0190, 1'b0}, '{3'h2, 16'h00c8, 1'b1},
        '{3'h3, 16'h00c8, 1'b1}, '{3'h3, 16'h0190, 1'b0}, '{3'h3, 16'h0032, 1'b0},
        '{3'h4, 16'h0190, 1'b1}, '{3'h4, 16'h00c8, 1'b0}, '{3'h0, 16'h0190, 1'b0}};
    always #10 ref_clk = ~ref_clk;
    trc_conv_model trc_conv_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .send(send),
        .value(val), .over(ov), .under(un), .meas(meas));
    trc_relay_ctrl #(.BOOT_LEN(20), .VIEW_LEN(50), .ALT_LEN(4), .TB_FAST(3), .TB_SLOW(5))
    trc_relay_ctrl_i (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .meas(meas), .key_up(k_up),
        .key_down(k_dn), .relay_out(relay), .led_out(led), .disp_kind(dk), .disp_value(dval));
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask
    task automatic samp(input logic [15:0] v, input logic o, input logic u, input int w);
        @(posedge ref_clk);
        send <= 1'b1;
        val <= v;
        ov <= o;
        un <= u;
        @(posedge ref_clk);
        send <= 1'b0;
        repeat (w) @(posedge ref_clk);
        #1;
    endtask
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        end_of_test;
    end
    initial begin
        repeat (19) @(posedge ref_clk);
        #1 `CHK({relay, led, dk}, {2'b00, trc_pkg::DK_IDENT})
        @(posedge ref_clk);
        rst_n <= 1'b1;
        rchk(trc_pkg::REG_SWING, trc_pkg::SWING_RST);
        rchk(trc_pkg::REG_SHOW, trc_pkg::SHOW_RST);
        rchk(4'hf, 16'h0000);
        `CHK(dk, trc_pkg::DK_IDENT)
        wreg(trc_pkg::REG_THR1, 16'h012c);
        wreg(trc_pkg::REG_THR2, 16'h0064);
        wreg(trc_pkg::REG_BAND, 16'h000a);
        wreg(trc_pkg::REG_SWING, 16'h7fff);
        repeat (25) @(posedge ref_clk);
        foreach (rows[i]) begin
            wreg(trc_pkg::REG_CTRL, {13'h0, rows[i].mode});
            samp(rows[i].v, 1'b0, 1'b0, 4);
            `CHK({relay, led}, {2{rows[i].exp}})
        end
        `CHK(dk, trc_pkg::DK_VALUE)
        samp(16'h2710, 1'b0, 1'b0, 4);
        `CHK(dk, trc_pkg::DK_OVER)
        samp(16'hfc18, 1'b0, 1'b0, 4);
        `CHK(dk, trc_pkg::DK_OVER)
        samp(16'hfc19, 1'b0, 1'b0, 4);
        `CHK(dk, trc_pkg::DK_VALUE)
        for (int f = 0; f < 3; f++) begin
            wreg(trc_pkg::REG_CTRL, {10'h0, f[1:0], 4'h1});
            samp(f == 1 ? 16'h00c8 : 16'h0190, 1'b0, 1'b0, 4);
            samp(f == 2 ? 16'h0190 : 16'h00c8, f != 0, f == 0, 4);
            `CHK({relay, dk}, {f != 2, f == 0 ? trc_pkg::DK_LOW : trc_pkg::DK_HIGH})
        end
        wreg(trc_pkg::REG_CTRL, 16'h0001);
        wreg(trc_pkg::REG_TON, 16'h0002);
        samp(16'h00c8, 1'b0, 1'b0, 4);
        samp(16'h0190, 1'b0, 1'b0, 2);
        samp(16'h00c8, 1'b0, 1'b0, 10);
        `CHK(relay, 1'b0)
        samp(16'h0190, 1'b0, 1'b0, 3);
        `CHK(relay, 1'b0)
        repeat (8) @(posedge ref_clk);
        #1 `CHK(relay, 1'b1)
        wreg(trc_pkg::REG_BAND, 16'h000a);
        #1 `CHK(relay, 1'b1)
        wreg(trc_pkg::REG_CTRL, 16'h0041);
        wreg(trc_pkg::REG_OFF_DELAY, 16'h0001);
        samp(16'h00c8, 1'b0, 1'b0, 5);
        `CHK(relay, 1'b1)
        repeat (2) @(posedge ref_clk);
        #1 `CHK(relay, 1'b0)
        wreg(trc_pkg::REG_CTRL, 16'h0003);
        @(posedge ref_clk);
        k_up <= 1'b1;
        @(posedge ref_clk);
        k_up <= 1'b0;
        @(posedge ref_clk);
        #1 `CHK({dk, dval}, {trc_pkg::DK_NAME, 16'h0000})
        @(posedge ref_clk);
        k_dn <= 1'b1;
        @(posedge ref_clk);
        k_dn <= 1'b0;
        @(posedge ref_clk);
        #1 `CHK({dk, dval}, {trc_pkg::DK_NAME, 16'h0001})
        @(posedge ref_clk);
        #1 `CHK({dk, dval}, {trc_pkg::DK_THR, 16'h0064})
        repeat (60) @(posedge ref_clk);
        #1 `CHK(dk, trc_pkg::DK_VALUE)
        wreg(trc_pkg::REG_CTRL, 16'h0009);
        wreg(trc_pkg::REG_SWING, 16'h0032);
        samp(16'h00c8, 1'b0, 1'b0, 0);
        samp(16'h0190, 1'b0, 1'b0, 0);
        samp(16'h00c8, 1'b0, 1'b0, 9);
        `CHK({relay, dk, dval}, {1'b1, trc_pkg::DK_VALUE, 16'h0190})
        repeat (40) @(posedge ref_clk);
        #1 `CHK({relay, dval}, {1'b0, 16'h00c8})
        samp(16'h0190, 1'b0, 1'b0, 9);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        #1 `CHK({relay, led, dk, rdata}, {2'b00, trc_pkg::DK_IDENT, 16'h0000})
        @(posedge ref_clk);
        rst_n <= 1'b1;
        rchk(trc_pkg::REG_SWING, trc_pkg::SWING_RST);
        `CHK({relay, dk}, {1'b0, trc_pkg::DK_IDENT})
        end_of_test;
    end
endmodule
`default_nettype wire
